// >>> hw/epp_host_port.sv
// Parallel port logic: EPP read cycle, shared register map and FIFO
// Function
// RL1: Stall host read while peripheral holds low.
// RL2: Software sets direction bit before reads.
// RL3: Assert data or address strobe on read.
// RL4: Keep waiting until hold released or timeout.
// RL5: Peripheral drives data, then releases hold.
// RL6: On termination answer host, drop strobe.
// RL7: Peripheral releases bus after strobe ends.
// RL8: Change select, direction, data after completion.
// RL9: Write select and strobes are active low.
// RL10: Interrupt input active high, rising edge.
// RL11: Peripheral hold line marks completion, readiness.
// RL12: Provide active-low peripheral reset output.
// RL13: During cycle only write select overridable.
// RL14: Standard and EPP modes share registers.
// RL15: All FIFO views share 16-byte FIFO.
// RL16: Config B reports chosen IRQ and DMA.
// RL17: Data, status, control usable every mode.
// RL18: Port words are eight bits wide.
// RL19: Watchdog aborts cycle, flags status bit 0.
// RL20: Strobes stay high outside read cycles.
`timescale 1ns/1ps
module epp_host_port
    import epp_port_pkg::*;
#(
    parameter int FIFO_DEPTH      = FIFO_DEPTH_DEF,
    parameter int TIMEOUT_CYCLES  = EPP_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    // Host request
    input  wire logic                         i_req_valid,
    input  wire epp_port_pkg::host_req_t      i_req,
    output logic                              o_req_ready,
    // Host answer
    output logic                              o_rsp_valid,
    output epp_port_pkg::host_rsp_t           o_rsp,
    input  wire logic                         i_rsp_ready,
    // Chip configuration
    input  wire logic                         i_epp_enable,
    input  wire logic [CFG_CHAN_W-1:0]        i_cfg_irq,
    input  wire logic [CFG_CHAN_W-1:0]        i_cfg_dma,
    // Parallel bus, split into three signals
    input  wire logic [WORD_W-1:0]            i_parallel_bus,
    output logic [WORD_W-1:0]                 o_parallel_bus,
    output logic                              o_parallel_bus_oe,
    // Peripheral control outputs
    output logic                              o_write_select_n,
    output logic                              o_data_phase_strobe_n,
    output logic                              o_address_phase_strobe_n,
    output logic                              o_peripheral_reset_n,
    output logic                              o_irq_line_level,
    // Peripheral status inputs
    input  wire logic                         i_peripheral_hold_n,
    input  wire logic                         i_peripheral_interrupt,
    input  wire logic                         i_busy,
    input  wire logic                         i_ack_n,
    input  wire logic                         i_paper_error,
    input  wire logic                         i_select,
    input  wire logic                         i_fault_n
);
    import epp_port_pkg::*;

    localparam int PW  = $clog2(FIFO_DEPTH);
    localparam int TW  = 12;

    // Parameter checks: power-of-two FIFO depth, timeout range
    if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two");
    end
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << TW)) begin : g_bad_timeout
        $error("TIMEOUT_CYCLES out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_STROBE  = 3'b010,
        ST_RELEASE = 3'b100
    } cyc_state_t;

    typedef struct packed {
        cyc_state_t                       state;
        logic [TW-1:0]                    timer;
        logic [WORD_W-1:0]                port_data;
        logic [WORD_W-1:0]                control;
        logic [WORD_W-1:0]                ecr;
        logic                             compress;
        logic                             timeout;
        logic [FIFO_DEPTH-1:0][WORD_W-1:0] fifo;
        logic [PW-1:0]                    wptr;
        logic [PW-1:0]                    rptr;
        logic [PW:0]                      count;
        logic                             req_ready;
        logic                             rsp_valid;
        host_rsp_t                        rsp;
        logic                             rsp1_valid;
        host_rsp_t                        rsp1;
        logic                             wsel_n;
        logic                             dstb_n;
        logic                             astb_n;
        logic [WORD_W-1:0]                pbus;
        logic                             pbus_oe;
        logic                             prst_n;
        logic                             irq;
    } port_state_t;

    port_state_t s_ff;
    port_state_t nxt_s;

    localparam logic [PW:0]   FIFO_FULL_CNT = (PW+1)'(FIFO_DEPTH);
    localparam logic [TW-1:0] TIMER_LAST    = TW'(TIMEOUT_CYCLES - 1);

    always_comb begin
        logic              take;
        logic              push;
        host_rsp_t         push_rsp;
        logic              fifo_empty;
        logic              fifo_full;
        logic              is_epp;
        take       = i_req_valid && s_ff.req_ready;
        push       = 1'b0;
        push_rsp   = '0;
        fifo_empty = (s_ff.count == '0);
        fifo_full  = (s_ff.count == FIFO_FULL_CNT);
        is_epp     = (i_req.sel == SEL_EPP_ADDRESS) || (i_req.sel == SEL_EPP_DATA);
        nxt_s      = s_ff;

        // Drain the answer buffer
        if (s_ff.rsp_valid && i_rsp_ready) begin
            nxt_s.rsp_valid  = s_ff.rsp1_valid;
            nxt_s.rsp        = s_ff.rsp1;
            nxt_s.rsp1_valid = 1'b0;
        end

        unique case (s_ff.state)
            ST_IDLE: begin
                if (take && !i_req.write && is_epp && i_epp_enable) begin
                    // RL3 strobe on read
                    nxt_s.state   = ST_STROBE;
                    nxt_s.timer   = '0;
                    nxt_s.pbus_oe = 1'b0;
                    // RL13 strobe bit forces write select
                    nxt_s.wsel_n  = !s_ff.control[CTL_STROBE_BIT];
                    if (i_req.sel == SEL_EPP_DATA) begin
                        nxt_s.dstb_n = 1'b0;
                    end else begin
                        nxt_s.astb_n = 1'b0;
                    end
                end else if (take) begin
                    push = 1'b0;
                    // RL17 shared registers in every mode
                    // RL14 one copy for both modes
                    unique case (i_req.sel)
                        SEL_PORT_DATA: begin
                            if (i_req.write) begin
                                nxt_s.port_data = i_req.wdata;
                            end else if (s_ff.control[CTL_DIR_BIT]) begin
                                push_rsp.rdata = i_parallel_bus;
                            end else begin
                                push_rsp.rdata = s_ff.port_data;
                            end
                        end
                        SEL_PORT_STATUS: begin
                            // RL19 timeout shows in bit 0
                            push_rsp.rdata = {!i_busy, i_ack_n, i_paper_error, i_select,
                                              i_fault_n, 2'b00, s_ff.timeout};
                            if (!i_req.write) begin
                                nxt_s.timeout = 1'b0;
                            end
                        end
                        SEL_PORT_CONTROL: begin
                            if (i_req.write) begin
                                nxt_s.control = i_req.wdata & CTL_WRITE_MASK;
                            end
                            push_rsp.rdata = s_ff.control;
                        end
                        SEL_ADDR_FIFO, SEL_COMPAT_FIFO, SEL_DATA_FIFO, SEL_TEST_FIFO: begin
                            // RL15 single shared FIFO
                            if (i_req.write) begin
                                if (!fifo_full) begin
                                    nxt_s.fifo[s_ff.wptr] = i_req.wdata;
                                    nxt_s.wptr  = s_ff.wptr + 1'b1;
                                    nxt_s.count = s_ff.count + 1'b1;
                                end
                            end else if (!fifo_empty && i_req.sel != SEL_COMPAT_FIFO) begin
                                push_rsp.rdata = s_ff.fifo[s_ff.rptr];
                                nxt_s.rptr  = s_ff.rptr + 1'b1;
                                nxt_s.count = s_ff.count - 1'b1;
                            end
                        end
                        SEL_CONFIG_A: begin
                            push_rsp.rdata = CONFIG_A_VALUE;
                        end
                        SEL_CONFIG_B: begin
                            // RL16 reports configured channels
                            if (i_req.write) begin
                                nxt_s.compress = i_req.wdata[CFGB_COMPRESS_BIT];
                            end
                            push_rsp.rdata = {s_ff.compress, s_ff.irq, i_cfg_irq, i_cfg_dma};
                        end
                        SEL_EXT_CONTROL: begin
                            if (i_req.write) begin
                                nxt_s.ecr = i_req.wdata & ECR_WRITE_MASK;
                            end
                            push_rsp.rdata = s_ff.ecr;
                            push_rsp.rdata[ECR_FULL_BIT]  = fifo_full;
                            push_rsp.rdata[ECR_EMPTY_BIT] = fifo_empty;
                        end
                        default: begin
                            push_rsp.rdata = '0;
                        end
                    endcase
                    push = 1'b1;
                end
                // RL8 pins follow control only between cycles
                // RL2 direction bit releases bus and write select
                if (nxt_s.state == ST_IDLE) begin
                    nxt_s.wsel_n  = nxt_s.control[CTL_DIR_BIT];
                    nxt_s.pbus_oe = !nxt_s.control[CTL_DIR_BIT];
                    nxt_s.pbus    = nxt_s.port_data;
                end
            end
            ST_STROBE: begin
                nxt_s.timer = s_ff.timer + 1'b1;
                // RL1 RL4 stall until hold released
                if (i_peripheral_hold_n) begin
                    // RL6 final answer and strobe removal
                    push           = 1'b1;
                    push_rsp.rdata = i_parallel_bus;
                    nxt_s.state    = ST_RELEASE;
                    nxt_s.dstb_n   = 1'b1;
                    nxt_s.astb_n   = 1'b1;
                end else if (s_ff.timer == TIMER_LAST) begin
                    // RL19 watchdog abort
                    push             = 1'b1;
                    push_rsp.timeout = 1'b1;
                    push_rsp.rdata   = i_parallel_bus;
                    nxt_s.timeout    = 1'b1;
                    nxt_s.state      = ST_RELEASE;
                    nxt_s.dstb_n     = 1'b1;
                    nxt_s.astb_n     = 1'b1;
                end
            end
            ST_RELEASE: begin
                // RL7 peripheral lets go of the bus
                nxt_s.state   = ST_IDLE;
                nxt_s.wsel_n  = s_ff.control[CTL_DIR_BIT];
                nxt_s.pbus_oe = !s_ff.control[CTL_DIR_BIT];
                nxt_s.pbus    = s_ff.port_data;
            end
        endcase

        // RL20 strobes idle high
        if (nxt_s.state == ST_IDLE) begin
            nxt_s.dstb_n = 1'b1;
            nxt_s.astb_n = 1'b1;
        end

        // Two-entry answer buffer
        if (push) begin
            if (!nxt_s.rsp_valid) begin
                nxt_s.rsp_valid = 1'b1;
                nxt_s.rsp       = push_rsp;
            end else begin
                nxt_s.rsp1_valid = 1'b1;
                nxt_s.rsp1       = push_rsp;
            end
        end
        nxt_s.req_ready = (nxt_s.state == ST_IDLE) && !nxt_s.rsp1_valid;

        // RL12 reset output from the init bit
        nxt_s.prst_n = nxt_s.control[CTL_INIT_BIT];

        // RL10 rising edge sets service flag, set beats clear
        nxt_s.irq = i_peripheral_interrupt;
        if (i_peripheral_interrupt && !s_ff.irq && s_ff.control[CTL_ACK_IRQ_BIT]) begin
            nxt_s.ecr[ECR_SERVICE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_ff           <= '0;
            s_ff.state     <= ST_IDLE;
            s_ff.port_data <= DATA_RESET;
            s_ff.control   <= CTL_RESET;
            s_ff.ecr       <= ECR_RESET;
            s_ff.wsel_n    <= 1'b1;
            s_ff.dstb_n    <= 1'b1;
            s_ff.astb_n    <= 1'b1;
            s_ff.pbus_oe   <= 1'b1;
            s_ff.prst_n    <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // RL9 active-low pins straight from flops
    assign o_req_ready              = s_ff.req_ready;
    assign o_rsp_valid              = s_ff.rsp_valid;
    assign o_rsp                    = s_ff.rsp;
    assign o_parallel_bus           = s_ff.pbus;
    assign o_parallel_bus_oe        = s_ff.pbus_oe;
    assign o_write_select_n         = s_ff.wsel_n;
    assign o_data_phase_strobe_n    = s_ff.dstb_n;
    assign o_address_phase_strobe_n = s_ff.astb_n;
    assign o_peripheral_reset_n     = s_ff.prst_n;
    assign o_irq_line_level         = s_ff.irq;

endmodule : epp_host_port

// >>> hw/epp_port_pkg.sv
// Shared constants and carrier types for the parallel host port
package epp_port_pkg;

    // Register selects on the host request port
    typedef enum logic [3:0] {
        SEL_PORT_DATA    = 4'h0,
        SEL_PORT_STATUS  = 4'h1,
        SEL_PORT_CONTROL = 4'h2,
        SEL_EPP_ADDRESS  = 4'h3,
        SEL_EPP_DATA     = 4'h4,
        SEL_ADDR_FIFO    = 4'h5,
        SEL_COMPAT_FIFO  = 4'h6,
        SEL_DATA_FIFO    = 4'h7,
        SEL_TEST_FIFO    = 4'h8,
        SEL_CONFIG_A     = 4'h9,
        SEL_CONFIG_B     = 4'hA,
        SEL_EXT_CONTROL  = 4'hB
    } reg_sel_t;

    localparam int  WORD_W = 8;

    typedef struct packed {
        logic              write;
        reg_sel_t          sel;
        logic [WORD_W-1:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic              timeout;
        logic [WORD_W-1:0] rdata;
    } host_rsp_t;

    // Port control bit positions
    localparam int CTL_STROBE_BIT  = 0;
    localparam int CTL_INIT_BIT    = 2;
    localparam int CTL_ACK_IRQ_BIT = 4;
    localparam int CTL_DIR_BIT     = 5;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h3F;
    localparam logic [7:0] CTL_RESET      = 8'h04;

    // Extended control bit positions
    localparam int ECR_EMPTY_BIT   = 0;
    localparam int ECR_FULL_BIT    = 1;
    localparam int ECR_SERVICE_BIT = 2;
    localparam logic [7:0] ECR_WRITE_MASK = 8'hFC;
    localparam logic [7:0] ECR_RESET      = 8'h00;

    // Config B bit positions
    localparam int CFGB_COMPRESS_BIT = 7;
    localparam int CFGB_IRQ_LVL_BIT  = 6;
    localparam int CFG_CHAN_W        = 3;

    localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
    localparam logic [7:0] DATA_RESET     = 8'h00;

    // Read cycle watchdog
    localparam int EPP_TIMEOUT_NS   = 10000;
    localparam int CLK_PERIOD_NS    = 4;
    localparam int EPP_TIMEOUT_CYC  = EPP_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH_DEF   = 16;

endpackage : epp_port_pkg

// >>> tb/epp_host_port_asserts.sv
// Concurrent checks on the parallel host port boundary
`timescale 1ns/1ps
module epp_host_port_asserts
    import epp_port_pkg::*;
#(
    parameter int FIFO_DEPTH     = FIFO_DEPTH_DEF,
    parameter int TIMEOUT_CYCLES = EPP_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic                    i_clk,
    input wire logic                    i_rst,
    // Host side
    input wire logic                    i_req_valid,
    input wire epp_port_pkg::host_req_t i_req,
    input wire logic                    o_req_ready,
    input wire logic                    o_rsp_valid,
    input wire epp_port_pkg::host_rsp_t o_rsp,
    input wire logic                    i_epp_enable,
    // Peripheral side
    input wire logic [WORD_W-1:0]       i_parallel_bus,
    input wire logic                    o_parallel_bus_oe,
    input wire logic                    o_write_select_n,
    input wire logic                    o_data_phase_strobe_n,
    input wire logic                    o_address_phase_strobe_n,
    input wire logic                    o_peripheral_reset_n,
    input wire logic                    o_irq_line_level,
    input wire logic                    i_peripheral_hold_n,
    input wire logic                    i_peripheral_interrupt
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    int   low_ff;
    logic in_rd;
    logic rd_take;
    assign in_rd = !o_data_phase_strobe_n || !o_address_phase_strobe_n;
    assign rd_take = i_req_valid && o_req_ready && !i_req.write && i_epp_enable;
    // Cycles spent with a strobe low
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            low_ff <= 0;
        end else begin
            low_ff <= in_rd ? low_ff + 1 : 0;
        end
    end
    property p_stall; in_rd && !i_peripheral_hold_n && low_ff < TIMEOUT_CYCLES - 2 |=> in_rd; endproperty
    a_stall: assert property (p_stall) else $error("read ended while held");
    property p_finish; in_rd && i_peripheral_hold_n
        |=> !in_rd && o_rsp_valid && !o_rsp.timeout && o_rsp.rdata == $past(i_parallel_bus); endproperty
    a_finish: assert property (p_finish) else $error("read not closed");
    property p_dstb; rd_take && i_req.sel == SEL_EPP_DATA |=> !o_data_phase_strobe_n; endproperty
    a_dstb: assert property (p_dstb) else $error("data strobe missing");
    property p_astb; rd_take && i_req.sel == SEL_EPP_ADDRESS |=> !o_address_phase_strobe_n; endproperty
    a_astb: assert property (p_astb) else $error("address strobe missing");
    property p_one; in_rd |-> !o_req_ready && o_data_phase_strobe_n != o_address_phase_strobe_n; endproperty
    a_one: assert property (p_one) else $error("strobe outside read");
    property p_rel; in_rd |-> !o_parallel_bus_oe; endproperty
    a_rel: assert property (p_rel) else $error("bus driven in read");
    property p_wsel; in_rd && $past(in_rd) |-> $stable(o_write_select_n); endproperty
    a_wsel: assert property (p_wsel) else $error("write select moved");
    property p_tmo; in_rd && !i_peripheral_hold_n ##1 !in_rd |-> o_rsp_valid && o_rsp.timeout; endproperty
    a_tmo: assert property (p_tmo) else $error("abort without timeout");
    property p_rst; i_req_valid && o_req_ready && i_req.write && i_req.sel == SEL_PORT_CONTROL
        && !i_req.wdata[CTL_INIT_BIT] |=> !o_peripheral_reset_n; endproperty
    a_rst: assert property (p_rst) else $error("reset out not low");
    property p_irq; $rose(i_peripheral_interrupt) |=> o_irq_line_level; endproperty
    a_irq: assert property (p_irq) else $error("interrupt not passed");
    c_read: cover property (in_rd && i_peripheral_hold_n);
    c_tmo: cover property (o_rsp_valid && o_rsp.timeout);
    c_rst: cover property (!o_peripheral_reset_n);
endmodule : epp_host_port_asserts

bind epp_host_port epp_host_port_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_asserts (
    .i_clk, .i_rst, .i_req_valid, .i_req, .o_req_ready, .o_rsp_valid, .o_rsp, .i_epp_enable,
    .i_parallel_bus, .o_parallel_bus_oe, .o_write_select_n, .o_data_phase_strobe_n,
    .o_address_phase_strobe_n, .o_peripheral_reset_n, .o_irq_line_level, .i_peripheral_hold_n,
    .i_peripheral_interrupt);

// >>> tb/epp_peripheral_model.sv
// Behavioural peripheral on the far side of the parallel bus
`timescale 1ns/1ps
module epp_peripheral_model (
    // Clock
    input  wire logic       i_clk,
    // Port side
    input  wire logic       i_strobe_n,
    input  wire logic [7:0] i_delay,
    input  wire logic [7:0] i_data,
    output logic            o_hold_n,
    output logic [7:0]      o_bus
);
    logic [7:0] cnt = 8'h00;
    initial o_hold_n = 1'b0;
    initial o_bus = 8'h00;
    always @(posedge i_clk) begin
        if (i_strobe_n) begin
            cnt <= 8'h00;
            // bus let go, ready for next
            o_hold_n <= 1'b0;
            o_bus <= ~o_bus;
        end else begin
            cnt <= cnt + 8'h01;
            if (cnt == i_delay) o_bus <= i_data;
            if (cnt == i_delay + 8'h01) o_hold_n <= 1'b1;
        end
    end
endmodule : epp_peripheral_model

// >>> tb/test_epp_read_ecp_register_map.sv
// Self-checking bench for the parallel host port
`timescale 1ns/1ps
module test_epp_read_ecp_register_map;
    import epp_port_pkg::*;
    logic       i_clk = 0, i_rst = 1, rq_v = 0, rs_r = 0, en = 1, peripheral_interrupt = 0, tmo;
    logic [4:0] st = 5'h0B;
    logic [2:0] irq_c = 3'h5, dma_c = 3'h3;
    logic [7:0] dly = 8'h00, pdat = 8'h00, bus_o, bus_i, per_bus, rd;
    logic       rq_r, rs_v, oe, wsn, dsn, asn, prn, irq_o, hold_n;
    host_req_t  rq = '0;
    host_rsp_t  rs;
    int         failures = 0, tests_run = 0;

    assign bus_i = oe ? bus_o : per_bus;
    initial forever #2 i_clk = ~i_clk;

    epp_host_port #(.TIMEOUT_CYCLES(20)) i_epp_host_port (
        .i_clk, .i_rst, .i_req_valid(rq_v), .i_req(rq), .o_req_ready(rq_r), .o_rsp_valid(rs_v),
        .o_rsp(rs), .i_rsp_ready(rs_r), .i_epp_enable(en), .i_cfg_irq(irq_c), .i_cfg_dma(dma_c),
        .i_parallel_bus(bus_i), .o_parallel_bus(bus_o), .o_parallel_bus_oe(oe), .o_write_select_n(wsn),
        .o_data_phase_strobe_n(dsn), .o_address_phase_strobe_n(asn), .o_peripheral_reset_n(prn),
        .o_irq_line_level(irq_o), .i_peripheral_hold_n(hold_n), .i_peripheral_interrupt(peripheral_interrupt),
        .i_busy(st[4]), .i_ack_n(st[3]), .i_paper_error(st[2]), .i_select(st[1]), .i_fault_n(st[0]));

    epp_peripheral_model i_epp_peripheral_model (
        .i_clk, .i_strobe_n(dsn & asn), .i_delay(dly), .i_data(pdat), .o_hold_n(hold_n), .o_bus(per_bus));

    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("Error %s: expected %h, seen %h", n, e, s);
        end
    endtask : check

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic op(input logic w, input reg_sel_t s, input logic [7:0] d, output logic [7:0] r, output logic t);
        int n = 0;
        @(negedge i_clk);
        rq_v = 1;
        rq = '{w, s, d};
        while (!rq_r && n < 100) begin @(negedge i_clk); n++; end
        @(negedge i_clk);
        rq_v = 0;
        while (!rs_v && n < 200) begin @(negedge i_clk); n++; end
        check("handshake", 8'(n >= 200), 8'h00);
        r = rs.rdata;
        t = rs.timeout;
        rs_r = 1;
        @(negedge i_clk);
        rs_r = 0;
    endtask : op

    task automatic t_regs();
        check("dstb idle", 8'(dsn), 8'h01);
        check("astb idle", 8'(asn), 8'h01);
        check("wsel idle", 8'(wsn), 8'h01);
        op(0, SEL_PORT_CONTROL, 8'h00, rd, tmo);
        check("control", rd, CTL_RESET);
        op(0, SEL_CONFIG_A, 8'h00, rd, tmo);
        check("config a", rd, CONFIG_A_VALUE);
        op(0, SEL_CONFIG_B, 8'h00, rd, tmo);
        check("config b", {2'b00, rd[5:0]}, {2'b00, irq_c, dma_c});
        op(0, SEL_PORT_STATUS, 8'h00, rd, tmo);
        check("status", rd, {~st[4], st[3:0], 3'b000});
        op(0, reg_sel_t'(4'hC), 8'h00, rd, tmo);
        check("unmapped", rd, 8'h00);
        peripheral_interrupt = 1;
        repeat (2) @(negedge i_clk);
        check("irq", 8'(irq_o), 8'h01);
        peripheral_interrupt = 0;
        $display("test regs done");
    endtask : t_regs

    task automatic t_control();
        op(1, SEL_PORT_CONTROL, 8'h00, rd, tmo);
        check("reset out", 8'(prn), 8'h00);
        check("bus oe", 8'(oe), 8'h01);
        op(1, SEL_PORT_DATA, 8'hA5, rd, tmo);
        op(0, SEL_PORT_DATA, 8'h00, rd, tmo);
        check("data", rd, 8'hA5);
        check("bus out", bus_o, 8'hA5);
        op(1, SEL_PORT_CONTROL, 8'h34, rd, tmo);
        check("bus off", 8'(oe), 8'h00);
        check("wsel", 8'(wsn), 8'h01);
        check("reset off", 8'(prn), 8'h01);
        peripheral_interrupt = 1;
        repeat (2) @(negedge i_clk);
        peripheral_interrupt = 0;
        op(0, SEL_EXT_CONTROL, 8'h00, rd, tmo);
        check("service", 8'(rd[ECR_SERVICE_BIT]), 8'h01);
        op(1, SEL_EXT_CONTROL, 8'h00, rd, tmo);
        op(0, SEL_EXT_CONTROL, 8'h00, rd, tmo);
        check("service clear", 8'(rd[ECR_SERVICE_BIT]), 8'h00);
        $display("test control done");
    endtask : t_control

    task automatic t_epp();
        reg_sel_t   s [3] = '{SEL_EPP_DATA, SEL_EPP_ADDRESS, SEL_EPP_DATA};
        logic [7:0] d [3] = '{8'h00, 8'h07, 8'h03};
        logic [7:0] v [3] = '{8'h5A, 8'hC3, 8'h81};
        for (int i = 0; i < 3; i++) begin
            dly = d[i];
            pdat = v[i];
            op(0, s[i], 8'h00, rd, tmo);
            check("epp data", rd, v[i]);
            check("epp tmo", 8'(tmo), 8'h00);
        end
        en = 0;
        op(0, SEL_EPP_DATA, 8'h00, rd, tmo);
        check("epp off", rd, 8'h00);
        en = 1;
        $display("test epp done");
    endtask : t_epp

    task automatic t_timeout();
        // Delay well past the watchdog; a value of FF would wrap the model's hold compare
        dly = 8'h40;
        st = 5'h14;
        op(0, SEL_EPP_DATA, 8'h00, rd, tmo);
        check("tmo", 8'(tmo), 8'h01);
        op(0, SEL_PORT_STATUS, 8'h00, rd, tmo);
        check("tmo bit", rd, {~st[4], st[3:0], 3'b001});
        op(0, SEL_PORT_STATUS, 8'h00, rd, tmo);
        check("tmo clear", rd, {~st[4], st[3:0], 3'b000});
        dly = 8'h00;
        $display("test timeout done");
    endtask : t_timeout

    task automatic t_fifo();
        for (int i = 0; i < 17; i++) begin
            op(1, reg_sel_t'(i < 8 ? SEL_ADDR_FIFO : SEL_DATA_FIFO), 8'(i * 17), rd, tmo);
        end
        op(0, SEL_EXT_CONTROL, 8'h00, rd, tmo);
        check("full", 8'(rd[ECR_FULL_BIT]), 8'h01);
        for (int i = 0; i < 16; i++) begin
            op(0, reg_sel_t'(i < 8 ? SEL_TEST_FIFO : SEL_DATA_FIFO), 8'h00, rd, tmo);
            check("fifo", rd, 8'(i * 17));
        end
        op(0, SEL_EXT_CONTROL, 8'h00, rd, tmo);
        check("empty", 8'(rd[ECR_EMPTY_BIT]), 8'h01);
        op(0, SEL_TEST_FIFO, 8'h00, rd, tmo);
        check("underrun", rd, 8'h00);
        $display("test fifo done");
    endtask : t_fifo

    initial begin
        repeat (20) @(negedge i_clk);
        i_rst = 0;
        t_regs();
        t_control();
        t_epp();
        t_timeout();
        t_fifo();
        end_of_test();
    end

    initial begin
        #40000;
        failures++;
        $display("Error watchdog: expected done, seen hang");
        end_of_test();
    end
endmodule : test_epp_read_ecp_register_map
